// file: core/ptt_pkg.sv
// package: register map, fields and constants of the periodic tick timer
`default_nettype none
package ptt_pkg;
   localparam int unsigned ADDR_W = 8;
   // register byte offsets
   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_PRESC = 8'h04;
   localparam logic [7:0] OFF_RELOAD = 8'h08;
   localparam logic [7:0] OFF_CSR = 8'h0C;
   localparam logic [7:0] OFF_COUNT = 8'h10;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFF_MODE = 8'h1C;
   // cfg fields
   localparam int unsigned CFG_LOCK_CFG = 0;
   localparam int unsigned CFG_LOCK_PRESC = 1;
   localparam int unsigned CFG_LOCK_TMR = 2;
   // csr fields
   localparam int unsigned CSR_RST = 0;
   localparam int unsigned CSR_TC = 1;
   localparam int unsigned CSR_IEN = 2;
   // mode field: power state of the device
   localparam logic [1:0] MODE_ACTIVE = 2'h0;
   localparam logic [1:0] MODE_HALT = 2'h3;
   // prescaler field
   localparam int unsigned PRESC_W = 3;
   localparam logic [2:0] PRESC_MAX = 3'h5;
   localparam int unsigned DIV_W = 5;
   localparam logic [15:0] RELOAD_RST = 16'hFFFF;
   // slow reference clock: 32.768 kHz, derived from aclk (200 MHz)
   localparam longint unsigned ACLK_HZ = 200000000;
   localparam longint unsigned SLOW_HZ = 32768;
   localparam int unsigned SLOW_DIV = int'(ACLK_HZ / SLOW_HZ);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ptt_pkg
`default_nettype wire

// file: core/ptt_slow_div.sv
// slow reference clock enable divider with freeze input
`default_nettype none
module ptt_slow_div #(
   parameter int unsigned DIV = 6103
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic freeze,
   output logic slow_en
);
   logic [15:0] cnt_q, cnt_d;
   logic en_d;
   // count down; one pulse per wrap, hold while frozen
   always_comb begin
      cnt_d = cnt_q;
      en_d = 1'b0;
      if (!freeze) begin
         if (cnt_q == 16'h0000) begin
            cnt_d = 16'(DIV - 1);
            en_d = 1'b1;
         end else begin
            cnt_d = cnt_q - 16'h0001;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 16'h0000;
         slow_en <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         slow_en <= en_d;
      end
   end
endmodule : ptt_slow_div
`default_nettype wire

// file: core/ptt_prescaler.sv
// prescaler: divides the slow enable by 1..32 into the tick enable
`default_nettype none
module ptt_prescaler (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic slow_en,
   input wire logic [2:0] sel,
   output logic tick_en
);
   logic [4:0] cnt_q, cnt_d;
   logic [4:0] lim;
   logic tick_d;
   // unused codes act as the largest divisor
   always_comb begin
      if (sel > ptt_pkg::PRESC_MAX) begin
         lim = 5'h1F;
      end else begin
         lim = 5'((6'h01 << sel) - 6'h01);
      end
      cnt_d = cnt_q;
      tick_d = 1'b0;
      if (slow_en) begin
         if (cnt_q >= lim) begin
            cnt_d = 5'h00;
            tick_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 5'h01;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 5'h00;
         tick_en <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_en <= tick_d;
      end
   end
endmodule : ptt_prescaler
`default_nettype wire

// file: core/ptt_timer.sv
// periodic tick timer top: AXI4-Lite registers, prescaler, reload counter
`default_nettype none
module ptt_timer #(
   parameter int unsigned SLOW_DIV = ptt_pkg::SLOW_DIV
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic tick_irq,
   output logic terminal_pulse,
   output logic wakeup_terminal
);
   logic slow_en, tick_en, halt;
   logic [2:0] lock_q, lock_d;
   logic [2:0] presc_q, presc_d;
   logic [15:0] reload_q, reload_d;
   logic [15:0] count_q, count_d;
   logic restart_q, restart_d;
   logic ien_q, ien_d;
   logic tc_q, tc_d;
   logic pulse_q, pulse_d;
   logic [1:0] mode_q, mode_d;
   logic stat_q, stat_d;
   logic mask_q, mask_d;
   logic irq_d;
   logic tick_go, hold_q, hold_d; // tick caught while halted
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [7:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic wr_go, rd_go, wr_bad, zero_hit;
   logic [31:0] rmux;
   logic rbad;

   assign halt = (mode_q == ptt_pkg::MODE_HALT);
   // a tick that lands in the first two halted cycles waits, so none is lost
   assign tick_go = (tick_en || hold_q) && !halt;

   ptt_slow_div #(.DIV(SLOW_DIV)) u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .freeze(halt),
      .slow_en(slow_en)
   );

   ptt_prescaler u_presc (
      .aclk(aclk),
      .aresetn(aresetn),
      .slow_en(slow_en),
      .sel(presc_q),
      .tick_en(tick_en)
   );

   // write channel capture: address and data in either order
   assign wr_go = aw_q && w_q && !bv_q;
   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      awa_d = awa_q;
      wd_d = wd_q;
      bv_d = bv_q;
      br_d = br_q;
      if (s_axi_awvalid && !aw_q) begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
      end
      if (wr_go) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         br_d = wr_bad ? ptt_pkg::RESP_SLVERR : ptt_pkg::RESP_OKAY;
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
   end

   // unmapped write offsets answer slverr
   always_comb begin
      unique case (awa_q)
         ptt_pkg::OFF_CFG, ptt_pkg::OFF_PRESC, ptt_pkg::OFF_RELOAD,
         ptt_pkg::OFF_CSR, ptt_pkg::OFF_COUNT, ptt_pkg::OFF_IRQ_STAT,
         ptt_pkg::OFF_IRQ_MASK, ptt_pkg::OFF_MODE: wr_bad = 1'b0;
         default: wr_bad = 1'b1;
      endcase
   end

   // read path: one registered answer per address
   assign rd_go = s_axi_arvalid && !rv_q;
   always_comb begin
      rmux = 32'h0000_0000;
      rbad = 1'b0;
      unique case (s_axi_araddr)
         ptt_pkg::OFF_CFG: rmux = {29'h0, lock_q};
         ptt_pkg::OFF_PRESC: rmux = {29'h0, presc_q};
         ptt_pkg::OFF_RELOAD: rmux = {16'h0, reload_q};
         ptt_pkg::OFF_CSR: rmux = {29'h0, ien_q, tc_q, restart_q};
         ptt_pkg::OFF_COUNT: rmux = {16'h0, count_q};
         ptt_pkg::OFF_IRQ_STAT: rmux = {31'h0, stat_q};
         ptt_pkg::OFF_IRQ_MASK: rmux = {31'h0, mask_q};
         ptt_pkg::OFF_MODE: rmux = {30'h0, mode_q};
         default: rbad = 1'b1;
      endcase
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (rd_go) begin
         rv_d = 1'b1;
         rd_d = rmux;
         rr_d = rbad ? ptt_pkg::RESP_SLVERR : ptt_pkg::RESP_OKAY;
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end

   // register writes, counter, flags and interrupt
   always_comb begin
      lock_d = lock_q;
      presc_d = presc_q;
      reload_d = reload_q;
      restart_d = restart_q;
      ien_d = ien_q;
      tc_d = tc_q;
      mode_d = mode_q;
      stat_d = stat_q;
      mask_d = mask_q;
      count_d = count_q;
      pulse_d = pulse_q;
      hold_d = hold_q;
      zero_hit = 1'b0;
      if (wr_go && s_axi_wstrb[0]) begin
         unique case (awa_q)
            ptt_pkg::OFF_CFG: begin
               if (!lock_q[ptt_pkg::CFG_LOCK_CFG]) begin
                  lock_d = lock_q | wd_q[2:0];
               end
            end
            ptt_pkg::OFF_PRESC: begin
               if (!lock_q[ptt_pkg::CFG_LOCK_PRESC]) begin
                  presc_d = wd_q[2:0];
               end
            end
            ptt_pkg::OFF_RELOAD: begin
               if (!lock_q[ptt_pkg::CFG_LOCK_TMR]) begin
                  reload_d[7:0] = wd_q[7:0];
               end
            end
            ptt_pkg::OFF_CSR: begin
               if (!lock_q[ptt_pkg::CFG_LOCK_TMR]) begin
                  ien_d = wd_q[ptt_pkg::CSR_IEN];
                  if (wd_q[ptt_pkg::CSR_RST]) begin
                     restart_d = 1'b1;
                  end
                  if (wd_q[ptt_pkg::CSR_TC]) begin
                     tc_d = 1'b0;
                  end
               end
            end
            ptt_pkg::OFF_IRQ_STAT: begin
               if (wd_q[0]) begin
                  stat_d = 1'b0;
               end
            end
            ptt_pkg::OFF_IRQ_MASK: mask_d = wd_q[0];
            ptt_pkg::OFF_MODE: mode_d = wd_q[1:0];
            default: ;
         endcase
      end
      if (wr_go && s_axi_wstrb[1] && awa_q == ptt_pkg::OFF_RELOAD
          && !lock_q[ptt_pkg::CFG_LOCK_TMR]) begin
         reload_d[15:8] = wd_q[15:8];
      end
      // tick: count down, reload at zero or on restart; pulse one tick
      if (halt && tick_en) begin
         hold_d = 1'b1;
      end else if (tick_go) begin
         hold_d = 1'b0;
      end
      if (tick_go) begin
         pulse_d = 1'b0;
         if (restart_q) begin
            count_d = reload_q;
            restart_d = 1'b0;
         end else if (count_q == 16'h0000) begin
            count_d = reload_q;
         end else begin
            count_d = count_q - 16'h0001;
            if (count_d == 16'h0000) begin
               zero_hit = 1'b1;
            end
         end
         if (zero_hit) begin
            pulse_d = 1'b1;
            tc_d = 1'b1;
            if (ien_q) begin
               stat_d = 1'b1;
            end
         end
      end
      irq_d = stat_d && mask_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_q <= 3'h0;
         presc_q <= 3'h0;
         reload_q <= ptt_pkg::RELOAD_RST;
         count_q <= ptt_pkg::RELOAD_RST;
         restart_q <= 1'b0;
         ien_q <= 1'b0;
         tc_q <= 1'b0;
         pulse_q <= 1'b0;
         hold_q <= 1'b0;
         mode_q <= ptt_pkg::MODE_ACTIVE;
         stat_q <= 1'b0;
         mask_q <= 1'b0;
         tick_irq <= 1'b0;
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         bv_q <= 1'b0;
         br_q <= 2'h0;
         rv_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         rr_q <= 2'h0;
      end else begin
         lock_q <= lock_d;
         presc_q <= presc_d;
         reload_q <= reload_d;
         count_q <= count_d;
         restart_q <= restart_d;
         ien_q <= ien_d;
         tc_q <= tc_d;
         pulse_q <= pulse_d;
         hold_q <= hold_d;
         mode_q <= mode_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
         tick_irq <= irq_d;
         aw_q <= aw_d;
         w_q <= w_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         bv_q <= bv_d;
         br_q <= br_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
      end
   end

   // pulse copies to the outputs and the wakeup path, all registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         terminal_pulse <= 1'b0;
         wakeup_terminal <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_arready <= 1'b0;
      end else begin
         terminal_pulse <= pulse_d;
         wakeup_terminal <= pulse_d;
         s_axi_awready <= !aw_d && !(s_axi_awvalid && !aw_q);
         s_axi_wready <= !w_d && !(s_axi_wvalid && !w_q);
         s_axi_arready <= !rv_d && !rd_go;
      end
   end

   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;

   // checks
   a_pulse_sets_tc: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(pulse_q) |-> tc_q)
      else $error("terminal pulse without flag");
   a_restart_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      (restart_q && tick_go)
      |=> (!restart_q && count_q == $past(reload_q)))
      else $error("restart not done");
   a_lock_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> ((lock_q & $past(lock_q)) == $past(lock_q)))
      else $error("lock released");
   a_halt_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
      halt |=> $stable(count_q))
      else $error("count moved in halt");
   a_irq_gated: assert property (@(posedge aclk) disable iff (!aresetn)
      tick_irq |-> mask_q)
      else $error("masked irq");
   a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick_go && !restart_q && count_q != 16'h0000)
      |=> count_q == $past(count_q) - 16'h0001)
      else $error("bad decrement");
   a_zero_reload: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick_go && count_q == 16'h0000)
      |=> count_q == $past(reload_q))
      else $error("no reload at zero");
   a_wake_copy: assert property (@(posedge aclk) disable iff (!aresetn)
      wakeup_terminal == terminal_pulse)
      else $error("wakeup path differs");
   c_pulse: cover property (@(posedge aclk) $rose(terminal_pulse));
   c_irq: cover property (@(posedge aclk) $rose(tick_irq));
   c_restart: cover property (@(posedge aclk) $fell(restart_q));
endmodule : ptt_timer
`default_nettype wire

// file: dv/ptt_irq_sink.sv
// model of the interrupt controller and wakeup unit fed by the timer
`default_nettype none
module ptt_irq_sink (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick_irq,
   input wire logic wakeup_terminal,
   output int n_wake,
   output logic irq_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wake_q;
   // wakeup input counts rising edges, controller latches the level
   always @(posedge aclk) begin
      if (!aresetn) begin
         n_wake <= 0;
         wake_q <= 1'b0;
         irq_level <= 1'b0;
      end else begin
         wake_q <= wakeup_terminal;
         irq_level <= tick_irq; // level request
         if (wakeup_terminal && !wake_q) begin
            n_wake <= n_wake + 1;
         end
      end
   end
endmodule : ptt_irq_sink
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the periodic tick timer over its register bus
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned SD = 3;
   localparam logic [7:0] ROFF [7] = '{ptt_pkg::OFF_CFG, ptt_pkg::OFF_PRESC,
      ptt_pkg::OFF_RELOAD, ptt_pkg::OFF_CSR, ptt_pkg::OFF_IRQ_STAT,
      ptt_pkg::OFF_IRQ_MASK, ptt_pkg::OFF_MODE};
   localparam logic [31:0] RVAL [7] = '{32'h0, 32'h0, 32'h0000FFFF, 32'h0,
      32'h0, 32'h0, 32'h0};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rd, a;
   logic tick_irq, terminal_pulse, wakeup_terminal, irq_level;
   int n_wake, per, wid, dv, k;
   int n_fail = 0;
   int compares = 0;

   ptt_timer #(.SLOW_DIV(SD)) i_ptt_timer (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .tick_irq(tick_irq), .terminal_pulse(terminal_pulse),
      .wakeup_terminal(wakeup_terminal)
   );
   ptt_irq_sink i_ptt_irq_sink (
      .aclk(aclk), .aresetn(aresetn), .tick_irq(tick_irq),
      .wakeup_terminal(wakeup_terminal), .n_wake(n_wake),
      .irq_level(irq_level)
   );

   // 200 MHz clock
   initial begin
      forever #2.5 aclk = ~aclk;
   end

   task automatic summarize();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic tmo();
      n_fail++;
      $display("mismatch wait expected done seen timeout");
      summarize();
   endtask : tmo

   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      bit aw_ok;
      bit w_ok;
      int i;
      aw_ok = 0;
      w_ok = 0;
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
         if (bvalid === 1'b1) begin
            rs = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (i == 100) tmo();
      @(posedge aclk);
   endtask : wr

   task automatic rdr(input logic [7:0] ad);
      bit ar_ok;
      int i;
      ar_ok = 0;
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (!ar_ok && arready === 1'b1) begin
            ar_ok = 1;
            arvalid <= 1'b0;
         end
         if (rvalid === 1'b1) begin
            rd = rdata;
            rs = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (i == 100) tmo();
      @(posedge aclk);
   endtask : rdr

   // cycles up to the next rising terminal pulse, and the pulse width
   task automatic to_rise(output int n, output int w);
      logic prev;
      prev = terminal_pulse;
      n = 0;
      w = 1;
      while (n < 3000) begin
         @(posedge aclk);
         n++;
         if (wakeup_terminal !== terminal_pulse)
            chk("wakeup copy", wakeup_terminal, terminal_pulse);
         if (terminal_pulse === 1'b1 && prev === 1'b0) break;
         if (terminal_pulse === 1'b1) w++;
         prev = terminal_pulse;
      end
      if (n >= 3000) tmo();
   endtask : to_rise

   // main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (k = 0; k < 7; k++) begin
         rdr(ROFF[k]);
         chk("reset value", rd, RVAL[k]);
      end
      rdr(8'h20);
      chk("unmapped read", {rd[29:0], rs}, {30'h0, ptt_pkg::RESP_SLVERR});
      wr(8'h24, 32'h1);
      chk("unmapped write", rs, ptt_pkg::RESP_SLVERR);
      wr(ptt_pkg::OFF_RELOAD, 32'h1); // smallest legal reload
      wr(ptt_pkg::OFF_CSR, 32'h1);
      for (k = 0; k < 8; k++) begin
         wr(ptt_pkg::OFF_PRESC, 32'(k));
         dv = (k > 5) ? 32 : (1 << k);
         to_rise(per, wid);
         to_rise(per, wid);
         to_rise(per, wid);
         chk("period", per, 2 * dv * SD);
         chk("width", wid, dv * SD);
      end
      wr(ptt_pkg::OFF_PRESC, 32'h0);
      wr(ptt_pkg::OFF_RELOAD, 32'h7);
      repeat (3) to_rise(per, wid);
      chk("reload period", per, 8 * SD);
      fork
         begin
            repeat (4) @(posedge aclk);
            wr(ptt_pkg::OFF_RELOAD, 32'h3);
         end
         to_rise(per, wid);
      join
      chk("old period", per, 8 * SD);
      to_rise(per, wid);
      chk("new period", per, 4 * SD);
      // flag and interrupt with enable off, then on, then masked
      rdr(ptt_pkg::OFF_CSR);
      chk("tc flag", rd & 32'h2, 32'h2);
      rdr(ptt_pkg::OFF_IRQ_STAT);
      chk("status off", rd, 32'h0);
      wr(ptt_pkg::OFF_IRQ_MASK, 32'h1);
      wr(ptt_pkg::OFF_CSR, 32'h4);
      repeat (30) @(posedge aclk);
      chk("irq on", irq_level, 1'b1);
      wr(ptt_pkg::OFF_CSR, 32'h0);
      wr(ptt_pkg::OFF_IRQ_STAT, 32'h1);
      rdr(ptt_pkg::OFF_IRQ_STAT);
      chk("status clear", rd, 32'h0);
      chk("irq cleared", irq_level, 1'b0);
      wr(ptt_pkg::OFF_IRQ_MASK, 32'h0);
      wr(ptt_pkg::OFF_CSR, 32'h4);
      repeat (30) @(posedge aclk);
      rdr(ptt_pkg::OFF_IRQ_STAT);
      chk("status masked", rd, 32'h1);
      chk("irq masked", tick_irq, 1'b0);
      chk("wakeup edges", n_wake > 0, 1'b1);
      // restart bit clears itself after the reload
      wr(ptt_pkg::OFF_CSR, 32'h1);
      for (k = 0; k < 20; k++) begin
         rdr(ptt_pkg::OFF_CSR);
         if (rd[0] === 1'b0) break;
      end
      chk("restart clear", rd & 32'h1, 32'h0);
      // halt freezes the count; active resumes it
      wr(ptt_pkg::OFF_RELOAD, 32'h0000FFFF); // largest legal reload
      wr(ptt_pkg::OFF_CSR, 32'h1);
      repeat (30) @(posedge aclk);
      wr(ptt_pkg::OFF_MODE, 32'(ptt_pkg::MODE_HALT));
      rdr(ptt_pkg::OFF_COUNT);
      a = rd;
      repeat (60) @(posedge aclk);
      rdr(ptt_pkg::OFF_COUNT);
      chk("halt count", rd, a);
      wr(ptt_pkg::OFF_MODE, 32'(ptt_pkg::MODE_ACTIVE));
      repeat (60) @(posedge aclk);
      rdr(ptt_pkg::OFF_COUNT);
      chk("resumed", rd < a && rd > a - 32'd40, 1'b1);
      // locks hold writes off and stay set
      wr(ptt_pkg::OFF_PRESC, 32'h1);
      wr(ptt_pkg::OFF_CFG, 32'h6);
      wr(ptt_pkg::OFF_PRESC, 32'h3);
      wr(ptt_pkg::OFF_RELOAD, 32'h5);
      wr(ptt_pkg::OFF_CFG, 32'h0);
      rdr(ptt_pkg::OFF_PRESC);
      chk("locked presc", rd, 32'h1);
      rdr(ptt_pkg::OFF_RELOAD);
      chk("locked reload", rd, 32'h0000FFFF);
      rdr(ptt_pkg::OFF_CFG);
      chk("lock sticky", rd, 32'h6);
      wr(ptt_pkg::OFF_CFG, 32'h1);
      wr(ptt_pkg::OFF_CFG, 32'h0);
      rdr(ptt_pkg::OFF_CFG);
      chk("cfg self lock", rd, 32'h7);
      summarize();
   end
endmodule : tb
`default_nettype wire
